/* File: logic/dpt_rom_defs.svh */
/*
 * Offsets, field positions and fixed byte values of the discoverable
 * parameter table store. Assumes it is included by its bare name.
 */
`ifndef DPT_ROM_DEFS_SVH
`define DPT_ROM_DEFS_SVH

// ----------------------------------------------------------------------
// Command and table placement
// ----------------------------------------------------------------------
`define DPT_READ_OPCODE      8'h5A
`define DPT_FPT_BASE         8'h30
`define DPT_FPT_DWORDS       8'h09
`define DPT_FPT_LAST         8'h53
`define DPT_MPT_BASE         8'h60
`define DPT_MPT_LAST         8'h6B
`define DPT_BLANK            8'hFF

// ----------------------------------------------------------------------
// Flash parameter table offsets
// ----------------------------------------------------------------------
`define DPT_OFF_ERASE_CFG    8'h30
`define DPT_OFF_ERASE4K_OP   8'h31
`define DPT_OFF_MODES        8'h32
`define DPT_OFF_UNUSED33     8'h33
`define DPT_OFF_DENS0        8'h34
`define DPT_OFF_DENS3        8'h37
`define DPT_OFF_Q144_CFG     8'h38
`define DPT_OFF_Q144_OP      8'h39
`define DPT_OFF_Q114_CFG     8'h3A
`define DPT_OFF_Q114_OP      8'h3B
`define DPT_OFF_D112_CFG     8'h3C
`define DPT_OFF_D112_OP      8'h3D
`define DPT_OFF_D122_CFG     8'h3E
`define DPT_OFF_D122_OP      8'h3F
`define DPT_OFF_ALLMODE      8'h40
`define DPT_OFF_D222_CFG     8'h46
`define DPT_OFF_D222_OP      8'h47
`define DPT_OFF_Q444_CFG     8'h4A
`define DPT_OFF_Q444_OP      8'h4B
`define DPT_OFF_ER1_SIZE     8'h4C
`define DPT_OFF_ER1_OP       8'h4D
`define DPT_OFF_ER2_SIZE     8'h4E
`define DPT_OFF_ER2_OP       8'h4F
`define DPT_OFF_ER3_SIZE     8'h50
`define DPT_OFF_ER3_OP       8'h51
`define DPT_OFF_ER4_SIZE     8'h52
`define DPT_OFF_ER4_OP       8'h53

// ----------------------------------------------------------------------
// Maker parameter table offsets
// ----------------------------------------------------------------------
`define DPT_OFF_VMAX_LO      8'h60
`define DPT_OFF_VMAX_HI      8'h61
`define DPT_OFF_VMIN_LO      8'h62
`define DPT_OFF_VMIN_HI      8'h63
`define DPT_OFF_FEAT_LO      8'h64
`define DPT_OFF_FEAT_HI      8'h65
`define DPT_OFF_WRAP_OP      8'h66
`define DPT_OFF_WRAP_LEN     8'h67
`define DPT_OFF_LOCK0        8'h68
`define DPT_OFF_LOCK1        8'h69

// ----------------------------------------------------------------------
// Mode byte fields (byte 32H)
// ----------------------------------------------------------------------
`define DPT_ADDR_3B_ONLY     2'b00
`define DPT_ADDR_3OR4B       2'b01
`define DPT_ADDR_4B_ONLY     2'b10
`define DPT_MODE_D112        1'b1
`define DPT_MODE_DTR         1'b0
`define DPT_MODE_D122        1'b1
`define DPT_MODE_Q144        1'b1
`define DPT_MODE_Q114        1'b1
`define DPT_MODE_UNUSED      1'b1

// ----------------------------------------------------------------------
// Fixed byte values
// ----------------------------------------------------------------------
`define DPT_VAL_ERASE_CFG    8'hE5
`define DPT_VAL_ERASE4K_OP   8'h20
`define DPT_VAL_DENS_TOP     8'h01
`define DPT_Q144_WAIT        5'b00100
`define DPT_Q144_MODE        3'b010
`define DPT_Q144_OP          8'hEB
`define DPT_Q114_WAIT        5'b01000
`define DPT_Q114_MODE        3'b000
`define DPT_Q114_OP          8'h6B
`define DPT_D112_WAIT        5'b01000
`define DPT_D112_MODE        3'b000
`define DPT_D112_OP          8'h3B
`define DPT_D122_WAIT        5'b00010
`define DPT_D122_MODE        3'b010
`define DPT_D122_OP          8'hBB
`define DPT_VAL_ALLMODE      8'hEE
`define DPT_VAL_NOCFG        8'h00
`define DPT_ER1_SIZE         8'h0C
`define DPT_ER1_OP           8'h20
`define DPT_ER2_SIZE         8'h0F
`define DPT_ER2_OP           8'h52
`define DPT_ER3_SIZE         8'h10
`define DPT_ER3_OP           8'hD8
`define DPT_ER4_SIZE         8'h00
`define DPT_ER4_OP           8'hFF
`define DPT_VMAX             16'h3600
`define DPT_VMIN             16'h2700
`define DPT_SWRST_OP         8'h99
`define DPT_RST_ENABLE_OP    8'h66
`define DPT_WRAP_OP          8'h77
`define DPT_WRAP_LEN         8'h64
`define DPT_LOCK_WORD        16'hEBFC

`endif

/* File: logic/dpt_pkg.sv */
/*
 * Types of the discoverable parameter table store.
 * Assumes nothing of its surroundings.
 */
package dpt_pkg;

  typedef enum logic {
    DPT_IDLE,
    DPT_STREAM
  } dpt_state_e;

  typedef logic [7:0] dpt_byte_t;

endpackage : dpt_pkg

/* File: logic/dpt_rom.sv */
/*
 * Read-only discoverable parameter table store of a serial flash.
 * Assumes the command decoder on the same clock pulses read_start_in
 * with the received byte offset after the read opcode and dummy byte,
 * pulses byte_shifted_in when the byte on data_out has been shifted out,
 * and pulses read_end_in when chip select rises.
 */
`timescale 1ns/10ps
`include "dpt_rom_defs.svh"

module dpt_rom
  import dpt_pkg::*;
#(
  parameter int ADDR_W = 24
)
(
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  input  wire logic              read_start_in,
  input  wire logic [ADDR_W-1:0] start_offset_in,
  input  wire logic              byte_shifted_in,
  input  wire logic              read_end_in,
  output logic      [7:0]        data_out,
  output logic                   data_valid_out,
  output logic      [ADDR_W-1:0] offset_out
);

  // --------------------------------------------------------------------
  // Elaboration checks
  // --------------------------------------------------------------------
  generate
    if (ADDR_W < 9)
    begin : g_bad_width
      $error("dpt_rom: ADDR_W must be at least 9");
    end
  endgenerate

  // --------------------------------------------------------------------
  // Table contents
  // --------------------------------------------------------------------
  localparam dpt_byte_t MODES_BYTE = {`DPT_MODE_UNUSED, `DPT_MODE_Q114, `DPT_MODE_Q144,
                                      `DPT_MODE_D122, `DPT_MODE_DTR, `DPT_ADDR_3B_ONLY,
                                      `DPT_MODE_D112};
  localparam logic [15:0] FEAT_WORD = {1'b1, 1'b1, 1'b1, 1'b1, `DPT_SWRST_OP,
                                       1'b1, 1'b1, 1'b1, 1'b0};
  // Whole words held here so they split into bytes, low byte first
  localparam logic [15:0] VMAX_WORD = `DPT_VMAX;
  localparam logic [15:0] VMIN_WORD = `DPT_VMIN;
  localparam logic [15:0] LOCK_WORD = `DPT_LOCK_WORD;

  // Offsets outside both tables read as blank bytes
  function automatic dpt_byte_t table_byte(input logic [ADDR_W-1:0] off);
    logic [7:0] lo;
    dpt_byte_t  val;
    lo  = off[7:0];
    val = `DPT_BLANK;
    if (off[ADDR_W-1:8] == '0)
    begin
      case (lo)
        `DPT_OFF_ERASE_CFG:  val = `DPT_VAL_ERASE_CFG;
        `DPT_OFF_ERASE4K_OP: val = `DPT_VAL_ERASE4K_OP;
        `DPT_OFF_MODES:      val = MODES_BYTE;
        `DPT_OFF_DENS3:      val = `DPT_VAL_DENS_TOP;
        `DPT_OFF_Q144_CFG:   val = {`DPT_Q144_MODE, `DPT_Q144_WAIT};
        `DPT_OFF_Q144_OP:    val = `DPT_Q144_OP;
        `DPT_OFF_Q114_CFG:   val = {`DPT_Q114_MODE, `DPT_Q114_WAIT};
        `DPT_OFF_Q114_OP:    val = `DPT_Q114_OP;
        `DPT_OFF_D112_CFG:   val = {`DPT_D112_MODE, `DPT_D112_WAIT};
        `DPT_OFF_D112_OP:    val = `DPT_D112_OP;
        `DPT_OFF_D122_CFG:   val = {`DPT_D122_MODE, `DPT_D122_WAIT};
        `DPT_OFF_D122_OP:    val = `DPT_D122_OP;
        `DPT_OFF_ALLMODE:    val = `DPT_VAL_ALLMODE;
        `DPT_OFF_D222_CFG:   val = `DPT_VAL_NOCFG;
        `DPT_OFF_Q444_CFG:   val = `DPT_VAL_NOCFG;
        `DPT_OFF_ER1_SIZE:   val = `DPT_ER1_SIZE;
        `DPT_OFF_ER1_OP:     val = `DPT_ER1_OP;
        `DPT_OFF_ER2_SIZE:   val = `DPT_ER2_SIZE;
        `DPT_OFF_ER2_OP:     val = `DPT_ER2_OP;
        `DPT_OFF_ER3_SIZE:   val = `DPT_ER3_SIZE;
        `DPT_OFF_ER3_OP:     val = `DPT_ER3_OP;
        `DPT_OFF_ER4_SIZE:   val = `DPT_ER4_SIZE;
        `DPT_OFF_ER4_OP:     val = `DPT_ER4_OP;
        `DPT_OFF_VMAX_LO:    val = VMAX_WORD[7:0];
        `DPT_OFF_VMAX_HI:    val = VMAX_WORD[15:8];
        `DPT_OFF_VMIN_LO:    val = VMIN_WORD[7:0];
        `DPT_OFF_VMIN_HI:    val = VMIN_WORD[15:8];
        `DPT_OFF_FEAT_LO:    val = FEAT_WORD[7:0];
        `DPT_OFF_FEAT_HI:    val = FEAT_WORD[15:8];
        `DPT_OFF_WRAP_OP:    val = `DPT_WRAP_OP;
        `DPT_OFF_WRAP_LEN:   val = `DPT_WRAP_LEN;
        `DPT_OFF_LOCK0:      val = LOCK_WORD[7:0];
        `DPT_OFF_LOCK1:      val = LOCK_WORD[15:8];
        // Unused bytes of both tables (33H-36H, 41H-45H, 47H, 48H, 49H,
        // 4BH, 6AH, 6BH) are blank, which the default already gives
        default:             val = `DPT_BLANK;
      endcase
    end
    return val;
  endfunction : table_byte

  // --------------------------------------------------------------------
  // Read sequencing
  // --------------------------------------------------------------------
  dpt_state_e        state_reg;
  logic [ADDR_W-1:0] offset_reg;
  logic [ADDR_W-1:0] offset_next;
  dpt_byte_t         data_reg;
  logic              valid_reg;

  always_comb
  begin
    offset_next = offset_reg;
    if (read_start_in)
    begin
      offset_next = start_offset_in;
    end
    else if ((state_reg == DPT_STREAM) && byte_shifted_in)
    begin
      // Wraps past the top of the address space like a normal read
      offset_next = ADDR_W'(offset_reg + 1'b1);
    end
  end

  // Start wins over end in the same cycle: a new frame has begun
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      state_reg <= DPT_IDLE;
    end
    else
    begin
      case (state_reg)
        DPT_IDLE:
        begin
          if (read_start_in)
          begin
            state_reg <= DPT_STREAM;
          end
        end
        DPT_STREAM:
        begin
          if (read_end_in && !read_start_in)
          begin
            state_reg <= DPT_IDLE;
          end
        end
        default:
        begin
          state_reg <= DPT_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      offset_reg <= '0;
    end
    else
    begin
      offset_reg <= offset_next;
    end
  end

  // Byte is looked up from the next offset so it is ready in the same cycle as offset_out
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      data_reg <= `DPT_BLANK;
    end
    else
    begin
      data_reg <= table_byte(offset_next);
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      valid_reg <= 1'b0;
    end
    else if (read_start_in)
    begin
      valid_reg <= 1'b1;
    end
    else if (read_end_in)
    begin
      valid_reg <= 1'b0;
    end
  end

  assign data_out       = data_reg;
  assign data_valid_out = valid_reg;
  assign offset_out     = offset_reg;

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  property p_start_loads;
    @(posedge clk_in) disable iff (!rst_n_in)
    read_start_in |=> (offset_out == $past(start_offset_in)) && data_valid_out;
  endproperty
  a_start_loads: assert property (p_start_loads) else $error("start offset not loaded");

  property p_advance;
    @(posedge clk_in) disable iff (!rst_n_in)
    (data_valid_out && byte_shifted_in && !read_start_in && !read_end_in)
      |=> (offset_out == ADDR_W'($past(offset_out) + 1'b1));
  endproperty
  a_advance: assert property (p_advance) else $error("offset did not advance");

  property p_hold;
    @(posedge clk_in) disable iff (!rst_n_in)
    (!byte_shifted_in && !read_start_in) |=> $stable(offset_out) && $stable(data_out);
  endproperty
  a_hold: assert property (p_hold) else $error("offset moved without a shift");

  property p_burst;
    @(posedge clk_in) disable iff (!rst_n_in)
    (data_valid_out && (offset_out == ADDR_W'(`DPT_OFF_Q144_OP))
      && byte_shifted_in && !read_start_in && !read_end_in)
      ##1 (byte_shifted_in && !read_start_in && !read_end_in)
      |=> (data_out == `DPT_Q114_OP);
  endproperty
  a_burst: assert property (p_burst) else $error("burst from 39H wrong at 3BH");

  property p_modes;
    @(posedge clk_in) disable iff (!rst_n_in)
    (offset_out == ADDR_W'(`DPT_OFF_MODES)) |-> (data_out == 8'hF1) && (data_out[2:1] == 2'b00);
  endproperty
  a_modes: assert property (p_modes) else $error("mode byte wrong");

  property p_q144;
    @(posedge clk_in) disable iff (!rst_n_in)
    (offset_out == ADDR_W'(`DPT_OFF_Q144_CFG)) && byte_shifted_in && data_valid_out
      && !read_start_in && !read_end_in
      |-> (data_out == 8'h44) ##1 (data_out == 8'hEB);
  endproperty
  a_q144: assert property (p_q144) else $error("quad io entry wrong");

  property p_q114;
    @(posedge clk_in) disable iff (!rst_n_in)
    (offset_out == ADDR_W'(`DPT_OFF_Q114_CFG)) |-> (data_out == 8'h08);
  endproperty
  a_q114: assert property (p_q114) else $error("quad output entry wrong");

  property p_d112;
    @(posedge clk_in) disable iff (!rst_n_in)
    (offset_out == ADDR_W'(`DPT_OFF_D112_OP)) |-> (data_out == 8'h3B);
  endproperty
  a_d112: assert property (p_d112) else $error("dual output opcode wrong");

  property p_d122;
    @(posedge clk_in) disable iff (!rst_n_in)
    (offset_out == ADDR_W'(`DPT_OFF_D122_CFG)) |-> (data_out == 8'h42);
  endproperty
  a_d122: assert property (p_d122) else $error("dual io entry wrong");

  property p_allmode;
    @(posedge clk_in) disable iff (!rst_n_in)
    ((offset_out == ADDR_W'(`DPT_OFF_ALLMODE)) |-> (data_out == 8'hEE))
    and ((offset_out == ADDR_W'(`DPT_OFF_D222_OP)) |-> (data_out == 8'hFF));
  endproperty
  a_allmode: assert property (p_allmode) else $error("all-mode bytes wrong");

  property p_erase;
    @(posedge clk_in) disable iff (!rst_n_in)
    ((offset_out == ADDR_W'(`DPT_OFF_ER1_SIZE)) |-> (data_out == 8'h0C))
    and ((offset_out == ADDR_W'(`DPT_OFF_ER2_OP)) |-> (data_out == 8'h52))
    and ((offset_out == ADDR_W'(`DPT_OFF_ER3_OP)) |-> (data_out == 8'hD8));
  endproperty
  a_erase: assert property (p_erase) else $error("erase entry wrong");

  property p_erase4;
    @(posedge clk_in) disable iff (!rst_n_in)
    (offset_out == ADDR_W'(`DPT_OFF_ER4_SIZE)) |-> (data_out == 8'h00);
  endproperty
  a_erase4: assert property (p_erase4) else $error("erase four not absent");

  property p_supply;
    @(posedge clk_in) disable iff (!rst_n_in)
    ((offset_out == ADDR_W'(`DPT_OFF_VMAX_HI)) |-> (data_out == 8'h36))
    and ((offset_out == ADDR_W'(`DPT_OFF_VMIN_HI)) |-> (data_out == 8'h27));
  endproperty
  a_supply: assert property (p_supply) else $error("supply code wrong");

  property p_feat;
    @(posedge clk_in) disable iff (!rst_n_in)
    (offset_out == ADDR_W'(`DPT_OFF_FEAT_LO)) && byte_shifted_in && data_valid_out
      && !read_start_in && !read_end_in
      |-> (data_out == 8'h9E) ##1 (data_out == 8'hF9);
  endproperty
  a_feat: assert property (p_feat) else $error("feature word wrong");

  property p_wrap;
    @(posedge clk_in) disable iff (!rst_n_in)
    ((offset_out == ADDR_W'(`DPT_OFF_WRAP_OP)) |-> (data_out == 8'h77))
    and ((offset_out == ADDR_W'(`DPT_OFF_WRAP_LEN)) |-> (data_out == 8'h64));
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap entry wrong");

  property p_lock;
    @(posedge clk_in) disable iff (!rst_n_in)
    ((offset_out == ADDR_W'(`DPT_OFF_LOCK1)) |-> (data_out == 8'hEB))
    and ((offset_out == ADDR_W'(`DPT_MPT_LAST)) |-> (data_out == 8'hFF));
  endproperty
  a_lock: assert property (p_lock) else $error("lock word wrong");

  property p_end;
    @(posedge clk_in) disable iff (!rst_n_in)
    (read_end_in && !read_start_in) |=> !data_valid_out;
  endproperty
  a_end: assert property (p_end) else $error("valid stayed after end");

  property p_reset;
    @(posedge clk_in)
    !rst_n_in |=> (offset_out == '0) && !data_valid_out && (data_out == `DPT_BLANK);
  endproperty
  a_reset: assert property (p_reset) else $error("reset values wrong");

endmodule : dpt_rom

/* File: dv/dpt_host_model.sv */
/*
 * Host-side stand-in for the command decoder that feeds the parameter store.
 * Assumes it shares the store's clock and that the bench calls its tasks.
 */
`timescale 1ns/10ps

module dpt_host_model
#(
  parameter int ADDR_W = 24
)
(
  input  wire logic              clk_in,
  output logic                   read_start_out,
  output logic      [ADDR_W-1:0] start_offset_out,
  output logic                   byte_shifted_out,
  output logic                   read_end_out
);

  initial
  begin
    read_start_out   = 1'b0;
    start_offset_out = '0;
    byte_shifted_out = 1'b0;
    read_end_out     = 1'b0;
  end

  // ----------------------------------------------------------------------
  // Frame tasks
  // ----------------------------------------------------------------------
  // Offset is inverted outside the start pulse so a stale value never helps
  task automatic start_read(input logic [ADDR_W-1:0] off, input logic with_end);
    @(posedge clk_in);
    read_start_out   <= 1'b1;
    start_offset_out <= off;
    read_end_out     <= with_end;
    @(posedge clk_in);
    read_start_out   <= 1'b0;
    start_offset_out <= ~off;
    read_end_out     <= 1'b0;
  endtask : start_read

  // Holds the shift pulse for n edges, so n > 1 is back to back
  task automatic shift_bytes(input int n);
    @(posedge clk_in);
    byte_shifted_out <= 1'b1;
    repeat (n) @(posedge clk_in);
    byte_shifted_out <= 1'b0;
  endtask : shift_bytes

  task automatic end_read();
    @(posedge clk_in);
    read_end_out <= 1'b1;
    @(posedge clk_in);
    read_end_out <= 1'b0;
  endtask : end_read

endmodule : dpt_host_model

/* File: dv/discoverable_parameter_table_parameter_rom_test.sv */
/*
 * Self-checking bench for the parameter store, driven through the host model.
 * Assumes the store answers one cycle after each accepted request.
 */
`timescale 1ns/10ps

`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) \
  begin n_fail++; $display("[FAIL] %s exp %h got %h", nm, ex, got); end end

module discoverable_parameter_table_parameter_rom_test;
  import dpt_pkg::*;

  localparam int AW    = 24;
  localparam int LIMIT = 2000;
  localparam int NROWS = 39;

  // ----------------------------------------------------------------------
  // Rows: offset in the upper byte, expected table byte in the lower
  // ----------------------------------------------------------------------
  localparam logic [15:0] ROWS [NROWS] = '{
    16'h00FF, 16'h17FF, 16'h30E5, 16'h3120, 16'h32F1, 16'h33FF, 16'h3701,
    16'h3844, 16'h39EB, 16'h3A08, 16'h3B6B, 16'h3C08, 16'h3D3B,
    16'h3E42, 16'h3FBB, 16'h40EE, 16'h4600, 16'h47FF, 16'h4A00, 16'h4BFF,
    16'h4C0C, 16'h4D20, 16'h4E0F, 16'h4F52, 16'h5010, 16'h51D8, 16'h5200, 16'h53FF,
    16'h6000, 16'h6136, 16'h6200, 16'h6327, 16'h649E, 16'h65F9,
    16'h6677, 16'h6764, 16'h68FC, 16'h69EB, 16'h6BFF
  };

  logic            clk_in;
  logic            rst_n_in;
  logic            read_start;
  logic [AW-1:0]   start_offset;
  logic            byte_shifted;
  logic            read_end;
  logic [7:0]      data;
  logic            data_valid;
  logic [AW-1:0]   offset;
  int              n_fail;
  int              checked;
  int              cycles;

  dpt_host_model #(.ADDR_W(AW)) host (
    .clk_in           (clk_in),
    .read_start_out   (read_start),
    .start_offset_out (start_offset),
    .byte_shifted_out (byte_shifted),
    .read_end_out     (read_end)
  );

  dpt_rom #(.ADDR_W(AW)) DUT (
    .clk_in          (clk_in),
    .rst_n_in        (rst_n_in),
    .read_start_in   (read_start),
    .start_offset_in (start_offset),
    .byte_shifted_in (byte_shifted),
    .read_end_in     (read_end),
    .data_out        (data),
    .data_valid_out  (data_valid),
    .offset_out      (offset)
  );

  initial
  begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Anything not listed in the rows reads as blank
  function automatic dpt_byte_t exp_byte(input logic [AW-1:0] a);
    exp_byte = 8'hFF;
    for (int i = 0; i < NROWS; i++)
      if (a == {16'h0000, ROWS[i][15:8]})
        exp_byte = ROWS[i][7:0];
  endfunction : exp_byte

  task automatic check_state(input logic [AW-1:0] ex_off, input dpt_byte_t ex_dat, input logic ex_vld);
    @(negedge clk_in);
    `CHK("data_out", ex_dat, data)
    `CHK("offset_out", ex_off, offset)
    `CHK("data_valid_out", ex_vld, data_valid)
  endtask : check_state

  task automatic complete_run();
    if (n_fail == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  // Hang guard: counts as a mismatch and closes the run
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      n_fail++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    rst_n_in = 1'b0;
    n_fail   = 0;
    checked  = 0;
    cycles   = 0;
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1'b1;
    check_state(24'h000000, 8'hFF, 1'b0);

    for (int i = 0; i < NROWS; i++)
    begin
      host.start_read({16'h0000, ROWS[i][15:8]}, 1'b0);
      check_state({16'h0000, ROWS[i][15:8]}, ROWS[i][7:0], 1'b1);
    end
    host.end_read();
    check_state(24'h00006B, 8'hFF, 1'b0);

    // Mode byte fields
    host.start_read(24'h000032, 1'b0);
    @(negedge clk_in);
    `CHK("addr_len", 2'b00, data[2:1])
    `CHK("dtr_flag", 1'b0, data[3])
    `CHK("fast_modes", 5'b11111, {data[7:4], data[0]})

    // Stream across both tables and the blank gaps around them
    host.start_read(24'h00002E, 1'b0);
    for (int a = 'h2E; a < 'h6D; a++)
    begin
      check_state(a[AW-1:0], exp_byte(a[AW-1:0]), 1'b1);
      host.shift_bytes(1);
    end
    check_state(24'h00006D, 8'hFF, 1'b1);

    // Back-to-back shifts, then end; later shifts while idle are ignored
    host.start_read(24'h000060, 1'b0);
    host.shift_bytes(4);
    check_state(24'h000064, 8'h9E, 1'b1);
    host.end_read();
    check_state(24'h000064, 8'h9E, 1'b0);
    host.shift_bytes(1);
    check_state(24'h000064, 8'h9E, 1'b0);

    // Back-to-back burst from 39H lands on 3BH
    host.start_read(24'h000039, 1'b0);
    host.shift_bytes(2);
    check_state(24'h00003B, 8'h6B, 1'b1);

    // Offset wraps at the top of the address space
    host.start_read(24'hFFFFFE, 1'b0);
    host.shift_bytes(2);
    check_state(24'h000000, 8'hFF, 1'b1);

    // Start wins over end in the same cycle
    host.start_read(24'h000066, 1'b1);
    check_state(24'h000066, 8'h77, 1'b1);

    // Reset in mid-frame, then a fresh read
    host.start_read(24'h000051, 1'b0);
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    check_state(24'h000000, 8'hFF, 1'b0);
    host.start_read(24'h000052, 1'b0);
    check_state(24'h000052, 8'h00, 1'b1);
    host.shift_bytes(1);
    check_state(24'h000053, 8'hFF, 1'b1);

    complete_run();
  end

endmodule : discoverable_parameter_table_parameter_rom_test
